// ---- hw/reload_timer_pkg.sv ----
// Package for the dual mode reload timer: register map, field positions,
// reset values and clock divider figures.
// Assumes a 32-bit APB bus with byte addresses on word boundaries.
package reload_timer_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h04;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;

  // Timer control fields
  localparam int CTRL_HIGH_FLAG = 7;
  localparam int CTRL_LOW_FLAG = 6;
  localparam int CTRL_LOW_IRQ_EN = 5;
  localparam int CTRL_SPLIT = 3;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_EXT_SEL = 0;

  // Clock control fields
  localparam int CLK_HIGH_SEL = 6;
  localparam int CLK_LOW_SEL = 5;

  // Status and mask fields share one layout
  localparam int STAT_HIGH = 1;
  localparam int STAT_LOW = 0;

  // Timer interrupt enable position
  localparam int IEN_TIMER = 5;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_MASK = 2'h3;

  // Counting constants
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
endpackage

// ---- hw/dual_mode_reload_timer.sv ----
// Dual mode reload timer: one 16-bit or two 8-bit auto-reload timers with
// per-byte clock selection, sticky overflow flags and an interrupt output.
// Assumes an APB master on clk_sys and an external oscillator pin whose
// frequency does not exceed half of clk_sys.
//
// How it works
// - Two count bytes, split bit picks mode
// - Count on clock, clock/12 or ext/8
// - External clock synchronized to clk_sys, then divided
// - 16-bit wrap reloads both bytes, sets high flag
// - Timer interrupt enable requests on 16-bit overflow
// - Low enable adds low byte wrap requests
// - Split mode: each byte reloads on own overflow
// - Run bit gates only high byte in split
// - Select bit, external select choose byte clock
// - Split mode: each byte wrap sets its flag
// - Split: high overflow requests, low with enable
// - Flags cleared only by software writes
module dual_mode_reload_timer
  import reload_timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External oscillator
  input wire logic extClk,
  // Interrupt
  output logic irq
);

  localparam int SYS_CNT_W = $clog2(SYS_DIVIDE);
  localparam int EXT_CNT_W = $clog2(EXT_DIVIDE);
  localparam logic [SYS_CNT_W-1:0] SYS_LAST = SYS_CNT_W'(SYS_DIVIDE - 1);
  localparam logic [EXT_CNT_W-1:0] EXT_LAST = EXT_CNT_W'(EXT_DIVIDE - 1);

  // Decodes one mapped address
  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      ADDR_TIMER_CTRL, ADDR_CLOCK_CTRL, ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
      ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH, ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
      ADDR_IRQ_ENABLE: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Picks the tick for one byte from its select bit
  function automatic logic byteTick(input logic sysSel, input logic extSel,
                                    input logic t12, input logic tExt);
    if (sysSel) begin
      byteTick = 1'b1;
    end else if (extSel) begin
      byteTick = tExt;
    end else begin
      byteTick = t12;
    end
  endfunction

  logic [7:0] addr8;
  logic access;
  logic wrEn;
  logic [7:0] wByte;
  logic [31:0] rdValue;

  logic lowIrqEn_reg;
  logic split_reg;
  logic run_reg;
  logic extSel_reg;
  logic highSel_reg;
  logic lowSel_reg;
  logic timerIrqEn_reg;
  logic [1:0] mask_reg;
  logic highFlag_reg;
  logic lowFlag_reg;
  logic [7:0] countLow_reg;
  logic [7:0] countHigh_reg;
  logic [7:0] reloadLow_reg;
  logic [7:0] reloadHigh_reg;
  logic [7:0] countLow_next;
  logic [7:0] countHigh_next;

  logic [SYS_CNT_W-1:0] sysDiv_reg;
  logic tick12;
  logic extMeta_reg;
  logic extSync_reg;
  logic extPrev_reg;
  logic [EXT_CNT_W-1:0] extDiv_reg;
  logic tickExt_reg;

  logic lowTick;
  logic highTick;
  logic lowWrap;
  logic highWrap;

  assign addr8 = 8'(paddr);
  assign access = psel && penable;
  assign wrEn = access && pwrite;
  assign wByte = pwdata[7:0];

  // APB answers in the access cycle, no wait states
  assign pready = 1'b1;
  assign pslverr = access && !isMapped(addr8);

  // System clock divided by 12
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sysDiv_reg <= '0;
    end else if (sysDiv_reg == SYS_LAST) begin
      sysDiv_reg <= '0;
    end else begin
      sysDiv_reg <= sysDiv_reg + 1'b1;
    end
  end

  assign tick12 = (sysDiv_reg == SYS_LAST);

  // External oscillator: two-stage synchroniser, then edge count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      extMeta_reg <= 1'b0;
      extSync_reg <= 1'b0;
      extPrev_reg <= 1'b0;
    end else begin
      extMeta_reg <= extClk;
      extSync_reg <= extMeta_reg;
      extPrev_reg <= extSync_reg;
    end
  end

  // Edges are only seen reliably while extClk stays at or below half of clk_sys
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      extDiv_reg <= '0;
      tickExt_reg <= 1'b0;
    end else begin
      tickExt_reg <= 1'b0;
      if (extSync_reg && !extPrev_reg) begin
        extDiv_reg <= extDiv_reg + 1'b1;
        tickExt_reg <= (extDiv_reg == EXT_LAST);
      end
    end
  end

  // In 16-bit mode the low byte select drives the whole count
  assign lowTick = byteTick(lowSel_reg, extSel_reg, tick12, tickExt_reg);
  assign highTick = byteTick(highSel_reg, extSel_reg, tick12, tickExt_reg);

  // Count advance and reload
  always_comb begin
    countLow_next = countLow_reg;
    countHigh_next = countHigh_reg;
    lowWrap = 1'b0;
    highWrap = 1'b0;
    if (split_reg) begin
      if (lowTick) begin
        if (countLow_reg == BYTE_MAX) begin
          lowWrap = 1'b1;
          countLow_next = reloadLow_reg;
        end else begin
          countLow_next = countLow_reg + 1'b1;
        end
      end
      if (run_reg && highTick) begin
        if (countHigh_reg == BYTE_MAX) begin
          highWrap = 1'b1;
          countHigh_next = reloadHigh_reg;
        end else begin
          countHigh_next = countHigh_reg + 1'b1;
        end
      end
    end else if (run_reg && lowTick) begin
      if (countLow_reg == BYTE_MAX) begin
        lowWrap = 1'b1;
        if (countHigh_reg == BYTE_MAX) begin
          highWrap = 1'b1;
          countLow_next = reloadLow_reg;
          countHigh_next = reloadHigh_reg;
        end else begin
          countLow_next = '0;
          countHigh_next = countHigh_reg + 1'b1;
        end
      end else begin
        countLow_next = countLow_reg + 1'b1;
      end
    end
  end

  // Count bytes: a software write wins over the count advance
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      countLow_reg <= RESET_BYTE;
      countHigh_reg <= RESET_BYTE;
    end else begin
      countLow_reg <= countLow_next;
      countHigh_reg <= countHigh_next;
      if (wrEn && addr8 == ADDR_COUNT_LOW) begin
        countLow_reg <= wByte;
      end
      if (wrEn && addr8 == ADDR_COUNT_HIGH) begin
        countHigh_reg <= wByte;
      end
    end
  end

  // Reload bytes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reloadLow_reg <= RESET_BYTE;
      reloadHigh_reg <= RESET_BYTE;
    end else begin
      if (wrEn && addr8 == ADDR_RELOAD_LOW) begin
        reloadLow_reg <= wByte;
      end
      if (wrEn && addr8 == ADDR_RELOAD_HIGH) begin
        reloadHigh_reg <= wByte;
      end
    end
  end

  // Control and clock selection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowIrqEn_reg <= 1'b0;
      split_reg <= 1'b0;
      run_reg <= 1'b0;
      extSel_reg <= 1'b0;
      highSel_reg <= 1'b0;
      lowSel_reg <= 1'b0;
    end else begin
      if (wrEn && addr8 == ADDR_TIMER_CTRL) begin
        lowIrqEn_reg <= pwdata[CTRL_LOW_IRQ_EN];
        split_reg <= pwdata[CTRL_SPLIT];
        run_reg <= pwdata[CTRL_RUN];
        extSel_reg <= pwdata[CTRL_EXT_SEL];
      end
      if (wrEn && addr8 == ADDR_CLOCK_CTRL) begin
        highSel_reg <= pwdata[CLK_HIGH_SEL];
        lowSel_reg <= pwdata[CLK_LOW_SEL];
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timerIrqEn_reg <= 1'b0;
      mask_reg <= RESET_MASK;
    end else begin
      if (wrEn && addr8 == ADDR_IRQ_ENABLE) begin
        timerIrqEn_reg <= pwdata[IEN_TIMER];
      end
      if (wrEn && addr8 == ADDR_IRQ_MASK) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // Sticky flags: set wins over a write-one clear in the same cycle.
  // Control register writes do not touch them, so no read-modify-write
  // of control can lose an overflow.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      highFlag_reg <= 1'b0;
      lowFlag_reg <= 1'b0;
    end else begin
      if (highWrap) begin
        highFlag_reg <= 1'b1;
      end else if (wrEn && addr8 == ADDR_IRQ_STATUS && pwdata[STAT_HIGH]) begin
        highFlag_reg <= 1'b0;
      end
      if (lowWrap) begin
        lowFlag_reg <= 1'b1;
      end else if (wrEn && addr8 == ADDR_IRQ_STATUS && pwdata[STAT_LOW]) begin
        lowFlag_reg <= 1'b0;
      end
    end
  end

  // Level interrupt, held until software clears the flag or its enable or mask bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= timerIrqEn_reg &&
             ((highFlag_reg && mask_reg[STAT_HIGH]) ||
              (lowFlag_reg && lowIrqEn_reg && mask_reg[STAT_LOW]));
    end
  end

  // Value of the addressed register
  always_comb begin
    rdValue = '0;
    case (addr8)
      ADDR_TIMER_CTRL: begin
        rdValue[CTRL_HIGH_FLAG] = highFlag_reg;
        rdValue[CTRL_LOW_FLAG] = lowFlag_reg;
        rdValue[CTRL_LOW_IRQ_EN] = lowIrqEn_reg;
        rdValue[CTRL_SPLIT] = split_reg;
        rdValue[CTRL_RUN] = run_reg;
        rdValue[CTRL_EXT_SEL] = extSel_reg;
      end
      ADDR_CLOCK_CTRL: begin
        rdValue[CLK_HIGH_SEL] = highSel_reg;
        rdValue[CLK_LOW_SEL] = lowSel_reg;
      end
      ADDR_COUNT_LOW: rdValue[7:0] = countLow_reg;
      ADDR_COUNT_HIGH: rdValue[7:0] = countHigh_reg;
      ADDR_RELOAD_LOW: rdValue[7:0] = reloadLow_reg;
      ADDR_RELOAD_HIGH: rdValue[7:0] = reloadHigh_reg;
      ADDR_IRQ_STATUS: begin
        rdValue[STAT_HIGH] = highFlag_reg;
        rdValue[STAT_LOW] = lowFlag_reg;
      end
      ADDR_IRQ_MASK: rdValue[1:0] = mask_reg;
      ADDR_IRQ_ENABLE: rdValue[IEN_TIMER] = timerIrqEn_reg;
      default: rdValue = '0;
    endcase
  end

  // Read data is captured in the setup cycle so that prdata comes from a flop.
  // Limitation: a running count reads as it stood one clock before the access.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdValue;
    end else begin
      prdata <= '0;
    end
  end

endmodule // dual_mode_reload_timer

// ---- bench/ext_osc_model.sv ----
// Free-running external precision oscillator for the timer's external pin.
// Assumes the half period is longer than the system clock period.
module ext_osc_model #(
  parameter int HALF_NS = 20
) (
  // Oscillator pin
  output logic extClk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Slower than clk_sys so no synchronised edge is lost
  initial begin
    extClk = 1'b0;
    forever #(HALF_NS) extClk = ~extClk;
  end
endmodule // ext_osc_model

// ---- bench/dual_mode_reload_timer_chk.sv ----
// Port-level checker for the reload timer: APB answer and interrupt hold.
// Assumes it is bound to the top module and sees only its ports.
module dual_mode_reload_timer_chk
  import reload_timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extClk,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_rdata_idle: assert property (!acc |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  a_err_unmapped: assert property (acc && paddr > ADDR_IRQ_ENABLE |-> pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (acc && paddr == ADDR_COUNT_LOW |-> !pslverr)
    else $error("mapped address refused");
  a_err_rdata: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_write_quiet: assert property (wr |-> prdata == 32'h0)
    else $error("read data shown during a write");
  // Flags are sticky, so only a write can take the request away
  a_irq_hold: assert property (!wr ##1 (irq && !wr) |=> irq)
    else $error("irq dropped without a write");
endmodule // dual_mode_reload_timer_chk

bind dual_mode_reload_timer dual_mode_reload_timer_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .extClk(extClk), .irq(irq));

// ---- bench/dual_mode_reload_timer_tb.sv ----
// Self-checking bench: APB register calls with expected values.
// Assumes the checker is bound in and the oscillator model drives extClk.
module dual_mode_reload_timer_tb;
  import reload_timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, extClk, irq, lastErr;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  int n_fail, n_checks;
  dual_mode_reload_timer u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extClk(extClk), .irq(irq));
  ext_osc_model u_osc (.extClk(extClk));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata[7:0];
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic waitIrq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      $display("ERROR irqWait expected 1 seen %b", irq);
      n_fail++;
      close_out();
    end
  endtask
  task automatic irqIs(input logic e);
    repeat (3) @(posedge clk_sys);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc("ctrlReset", ADDR_TIMER_CTRL, 8'h00);
    rc("maskReset", ADDR_IRQ_MASK, 8'h03);
    rc("unmapped", 8'h24, 8'h00);
    chk("unmappedErr", 8'h01, {7'h0, lastErr});
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    rc("reloadHigh", ADDR_RELOAD_HIGH, 8'h12);
    // 16-bit wrap on the system clock
    wr(ADDR_CLOCK_CTRL, 8'h20);
    wr(ADDR_IRQ_ENABLE, 8'h20);
    wr(ADDR_COUNT_LOW, 8'hf0);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_TIMER_CTRL, 8'h04);
    waitIrq(100);
    wr(ADDR_TIMER_CTRL, 8'h00);
    rc("reloadedHigh", ADDR_COUNT_HIGH, 8'h12);
    xfer(1'b0, ADDR_COUNT_LOW, 8'h00);
    chk("reloadedLow", 8'h30, q & 8'hf0);
    repeat (20) @(posedge clk_sys);
    xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk("highFlag", 8'h02, q & 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h03);
    irqIs(1'b0);
    rc("statusClear", ADDR_IRQ_STATUS, 8'h00);
    // Low byte wrap request with the mask applied
    wr(ADDR_COUNT_LOW, 8'hf0);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h24);
    waitIrq(100);
    wr(ADDR_TIMER_CTRL, 8'h20);
    rc("carryHigh", ADDR_COUNT_HIGH, 8'h01);
    rc("lowOnly", ADDR_IRQ_STATUS, 8'h01);
    rc("ctrlLowFlag", ADDR_TIMER_CTRL, 8'h60);
    wr(ADDR_IRQ_MASK, 8'h02);
    irqIs(1'b0);
    wr(ADDR_IRQ_MASK, 8'h03);
    irqIs(1'b1);
    wr(ADDR_IRQ_STATUS, 8'h03);
    // Split mode: low byte free-running, high byte held by the run bit
    wr(ADDR_COUNT_LOW, 8'hf0);
    wr(ADDR_COUNT_HIGH, 8'h55);
    wr(ADDR_RELOAD_LOW, 8'ha0);
    wr(ADDR_TIMER_CTRL, 8'h28);
    waitIrq(100);
    wr(ADDR_TIMER_CTRL, 8'h20);
    rc("heldHigh", ADDR_COUNT_HIGH, 8'h55);
    rc("splitLowFlag", ADDR_IRQ_STATUS, 8'h01);
    xfer(1'b0, ADDR_COUNT_LOW, 8'h00);
    chk("lowReload", 8'ha0, q & 8'he0);
    wr(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_CLOCK_CTRL, 8'h60);
    wr(ADDR_COUNT_HIGH, 8'hf8);
    wr(ADDR_RELOAD_HIGH, 8'h77);
    wr(ADDR_TIMER_CTRL, 8'h0c);
    waitIrq(100);
    wr(ADDR_TIMER_CTRL, 8'h00);
    xfer(1'b0, ADDR_COUNT_HIGH, 8'h00);
    chk("highReload", 8'h70, q & 8'hf0);
    xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk("splitHighFlag", 8'h02, q & 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h03);
    // Divided rates: 120 clocks of /12, then 800 clocks of ext/8
    wr(ADDR_CLOCK_CTRL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h04);
    repeat (120) @(posedge clk_sys);
    wr(ADDR_TIMER_CTRL, 8'h00);
    xfer(1'b0, ADDR_COUNT_LOW, 8'h00);
    chk("sysDiv", 8'h01, {7'h0, (q inside {[8'd9:8'd11]})});
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h05);
    repeat (800) @(posedge clk_sys);
    wr(ADDR_TIMER_CTRL, 8'h01);
    xfer(1'b0, ADDR_COUNT_LOW, 8'h00);
    chk("extDiv", 8'h01, {7'h0, (q inside {[8'd9:8'd11]})});
    close_out();
  end
endmodule // dual_mode_reload_timer_tb
